// >>> rtl/daoc_fifo.sv
// Sample-pair FIFO with registered read data
`timescale 1ns/1ns
module daoc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic flush_i,
   input wire logic wr_valid_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   output logic wr_ready_o,
   output logic rd_valid_o,
   output logic [WIDTH-1:0] rd_data_o,
   input wire logic rd_ready_i,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("daoc_fifo: DEPTH must be a power of two, at least 2");
   end
   if (WIDTH < 1) begin : g_bad_width
      $error("daoc_fifo: WIDTH must be positive");
   end

   // ----------------------------------------
   // Storage and pointers
   // ----------------------------------------
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;
   logic [AW:0] cnt_q;
   logic [WIDTH-1:0] rd_data_q;
   logic rd_valid_q;

   wire full_w = (cnt_q == (AW+1)'(DEPTH));
   wire empty_w = (cnt_q == '0);
   wire wr_fire_w = wr_valid_i && !full_w;
   wire load_w = !empty_w && (!rd_valid_q || rd_ready_i);
   wire [AW:0] cnt_d = cnt_q + (AW+1)'(wr_fire_w) - (AW+1)'(load_w);

   assign wr_ready_o = !full_w;
   assign rd_valid_o = rd_valid_q;
   assign rd_data_o = rd_data_q;
   assign level_o = cnt_q;

   always_ff @(posedge sys_clk_i) begin
      if (wr_fire_w) begin
         mem_q[wptr_q] <= wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || flush_i) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         rd_valid_q <= 1'b0;
      end else begin
         wptr_q <= wptr_q + AW'(wr_fire_w);
         rptr_q <= rptr_q + AW'(load_w);
         cnt_q <= cnt_d;
         rd_valid_q <= load_w || (rd_valid_q && !rd_ready_i);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (load_w) begin
         rd_data_q <= mem_q[rptr_q];
      end
   end
endmodule

// >>> rtl/daoc_top.sv
// Dual converter output control: constants package and top module
// Summary of operation
// - A sample tick each period samples both channels; the clock alone paces it.
// - Enable input high puts that channel's outputs high impedance; low drives them, except B's upper 11 bits in interleave mode.
// - Conversion and output updating go on whatever the output enables are.
// - Sleep request high holds reduced power with no valid conversion.
// - During sleep outputs are undefined and buffered samples are discarded.
// - Select at supply level: offset binary, duty-cycle stabiliser on.
// - Select at ground: two's complement, duty-cycle stabiliser on.
// - Select at mid reference: two's complement, stabiliser bypassed.
// - Select floating: offset binary, stabiliser bypassed.
// - Select may change live; words for a few cycles after are flagged invalid.
// - Stabiliser, when on, accepts clock duty cycles from 20% to 80%.
// - Interleave low: channel A and B words on separate 12-bit buses.
// - Interleave high: both channels time-shared on the channel A bus.
// - In interleave mode B's lowest bit marks channel: high for A, low for B.
package daoc_pkg;
   // ----------------------------------------
   // Widths and select levels
   // ----------------------------------------
   localparam int SAMPLE_W = 12;
   localparam int FIFO_DEPTH = 16;
   localparam logic [1:0] FSS_GROUND = 2'h0;
   localparam logic [1:0] FSS_MIDREF = 2'h1;
   localparam logic [1:0] FSS_FLOAT = 2'h2;
   localparam logic [1:0] FSS_SUPPLY = 2'h3;
   localparam logic [SAMPLE_W-1:0] BUS_RESET = 12'h000;
   localparam logic [SAMPLE_W-1:0] OE_N_OFF = 12'hFFF;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_FREQ_MHZ = 20;
   localparam int WAKE_TIME_US = 500;
   localparam int WAKE_CYCLES_DEF = WAKE_TIME_US * CLK_FREQ_MHZ;
   localparam int SAMPLE_DIV_DEF = 2;
   localparam int FMT_SETTLE_DEF = 4;
   localparam int DCS_DUTY_MIN_PCT = 20;
   localparam int DCS_DUTY_MAX_PCT = 80;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [SAMPLE_W-1:0] a;
      logic [SAMPLE_W-1:0] b;
   } daoc_pair_t;

   typedef enum logic [1:0] {
      PS_RUN,
      PS_SLEEP,
      PS_WAKE
   } daoc_pwr_t;

   function automatic logic [SAMPLE_W-1:0] daoc_code(input logic [SAMPLE_W-1:0] w,
                                                    input logic twos);
      daoc_code = twos ? {~w[SAMPLE_W-1], w[SAMPLE_W-2:0]} : w;
   endfunction
endpackage

`timescale 1ns/1ns
module daoc_top import daoc_pkg::*; #(
   parameter int SAMPLE_DIV = SAMPLE_DIV_DEF,
   parameter int WAKE_CYCLES = WAKE_CYCLES_DEF,
   parameter int FMT_SETTLE = FMT_SETTLE_DEF
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire daoc_pair_t core_sample_i,
   input wire logic core_valid_i,
   output logic core_ready_o,
   output logic sample_tick_o,
   input wire logic sleep_request_i,
   input wire logic chan_a_out_enable_n_i,
   input wire logic chan_b_out_enable_n_i,
   input wire logic [1:0] format_stabiliser_select_i,
   input wire logic interleave_select_i,
   input wire logic output_hold_i,
   output logic [SAMPLE_W-1:0] chan_a_out_bus_o,
   output logic [SAMPLE_W-1:0] chan_a_out_oe_n_o,
   output logic [SAMPLE_W-1:0] chan_b_out_bus_o,
   output logic [SAMPLE_W-1:0] chan_b_out_oe_n_o,
   output logic out_valid_o,
   output logic stabiliser_en_o,
   output logic twos_complement_o
);
   localparam int DW = (SAMPLE_DIV > 2) ? $clog2(SAMPLE_DIV) : 1;
   localparam int WW = $clog2(WAKE_CYCLES + 1);
   localparam int SW = $clog2(FMT_SETTLE + 1);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (SAMPLE_DIV < 2) begin : g_bad_div
      $error("daoc_top: SAMPLE_DIV must be at least 2 for two words per period");
   end
   if (WAKE_CYCLES < 1 || FMT_SETTLE < 3) begin : g_bad_counts
      $error("daoc_top: WAKE_CYCLES must be >= 1 and FMT_SETTLE >= 3");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [DW-1:0] div_q;
   daoc_pwr_t pst_q;
   daoc_pwr_t pst_d;
   logic [WW-1:0] wake_q;
   logic [1:0] fss_q;
   logic [SW-1:0] settle_q;
   daoc_pair_t word_q;
   logic b_phase_q;
   logic [SAMPLE_W-1:0] a_bus_q;
   logic [SAMPLE_W-1:0] b_bus_q;
   logic [SAMPLE_W-1:0] a_oe_n_q;
   logic [SAMPLE_W-1:0] b_oe_n_q;
   logic valid_q;
   logic tick_q;
   logic ready_q;
   logic dcs_q;
   logic twos_q;

   // ----------------------------------------
   // Buffer
   // ----------------------------------------
   daoc_pair_t rd_pair_w;
   logic rd_valid_w;
   logic [LW-1:0] level_w;
   logic wr_ready_w;

   wire sleep_w = sleep_request_i;
   wire tick_w = (div_q == '0);
   wire pop_w = tick_w && rd_valid_w && !output_hold_i && !sleep_w;
   wire push_w = core_valid_i && ready_q && !sleep_w;

   daoc_fifo #(
      .WIDTH($bits(daoc_pair_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .flush_i(sleep_w),
      .wr_valid_i(push_w),
      .wr_data_i(core_sample_i),
      .wr_ready_o(wr_ready_w),
      .rd_valid_o(rd_valid_w),
      .rd_data_o(rd_pair_w),
      .rd_ready_i(pop_w),
      .level_o(level_w)
   );

   // ----------------------------------------
   // Select decode and power state
   // ----------------------------------------
   wire twos_w = (format_stabiliser_select_i == FSS_GROUND) ||
                 (format_stabiliser_select_i == FSS_MIDREF);
   wire dcs_w = (format_stabiliser_select_i == FSS_GROUND) ||
                (format_stabiliser_select_i == FSS_SUPPLY);
   wire fmt_chg_w = (format_stabiliser_select_i != fss_q);
   wire wake_done_w = (wake_q == '0);
   wire ready_d = !sleep_w && wr_ready_w && (level_w < LW'(FIFO_DEPTH - 1));

   always_comb begin
      pst_d = pst_q;
      unique case (pst_q)
         PS_RUN: if (sleep_w) pst_d = PS_SLEEP;
         PS_SLEEP: if (!sleep_w) pst_d = PS_WAKE;
         PS_WAKE: begin
            if (sleep_w) begin
               pst_d = PS_SLEEP;
            end else if (wake_done_w) begin
               pst_d = PS_RUN;
            end
         end
         default: pst_d = PS_SLEEP;
      endcase
   end

   wire [WW-1:0] wake_d = sleep_w ? WW'(WAKE_CYCLES) :
                          (wake_done_w ? wake_q : wake_q - WW'(1));
   wire [SW-1:0] settle_d = fmt_chg_w ? SW'(FMT_SETTLE) :
                            ((settle_q == '0) ? settle_q : settle_q - SW'(1));
   wire ok_w = (pst_q == PS_RUN) && (settle_q == '0) && !fmt_chg_w;

   // ----------------------------------------
   // Output word selection
   // ----------------------------------------
   wire mux_w = interleave_select_i;
   wire [SAMPLE_W-1:0] a_code_w = daoc_code(rd_pair_w.a, twos_w);
   wire [SAMPLE_W-1:0] b_code_w = daoc_code(rd_pair_w.b, twos_w);
   wire [SAMPLE_W-1:0] wb_code_w = daoc_code(word_q.b, twos_w);
   wire [SAMPLE_W-1:0] a_bus_d = pop_w ? a_code_w :
                                 (b_phase_q ? wb_code_w : a_bus_q);
   wire ind_d = pop_w ? 1'b1 : (b_phase_q ? 1'b0 : b_bus_q[0]);
   wire [SAMPLE_W-1:0] b_par_d = pop_w ? b_code_w : b_bus_q;
   wire [SAMPLE_W-1:0] b_bus_d = mux_w ? {{(SAMPLE_W-1){1'b0}}, ind_d} : b_par_d;
   wire [SAMPLE_W-1:0] a_oe_n_d = {SAMPLE_W{chan_a_out_enable_n_i}};
   wire [SAMPLE_W-1:0] b_oe_n_d = mux_w ?
        {{(SAMPLE_W-1){1'b1}}, chan_b_out_enable_n_i} :
        {SAMPLE_W{chan_b_out_enable_n_i}};
   wire valid_d = ok_w && !sleep_w && (pop_w || (valid_q && !tick_w));

   // ----------------------------------------
   // Sample divider and control registers
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         div_q <= '0;
         tick_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         div_q <= (div_q == DW'(SAMPLE_DIV - 1)) ? '0 : div_q + DW'(1);
         tick_q <= tick_w && !sleep_w;
         ready_q <= ready_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pst_q <= PS_SLEEP;
         wake_q <= WW'(WAKE_CYCLES);
         fss_q <= FSS_FLOAT;
         settle_q <= SW'(FMT_SETTLE);
      end else begin
         pst_q <= pst_d;
         wake_q <= wake_d;
         fss_q <= format_stabiliser_select_i;
         settle_q <= settle_d;
      end
   end

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         word_q <= '0;
         b_phase_q <= 1'b0;
         a_bus_q <= BUS_RESET;
         b_bus_q <= BUS_RESET;
      end else begin
         if (pop_w) begin
            word_q <= rd_pair_w;
         end
         b_phase_q <= pop_w && mux_w;
         a_bus_q <= a_bus_d;
         b_bus_q <= b_bus_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         a_oe_n_q <= OE_N_OFF;
         b_oe_n_q <= OE_N_OFF;
         valid_q <= 1'b0;
         dcs_q <= 1'b0;
         twos_q <= 1'b0;
      end else begin
         a_oe_n_q <= a_oe_n_d;
         b_oe_n_q <= b_oe_n_d;
         valid_q <= valid_d;
         dcs_q <= dcs_w;
         twos_q <= twos_w;
      end
   end

   assign core_ready_o = ready_q;
   assign sample_tick_o = tick_q;
   assign chan_a_out_bus_o = a_bus_q;
   assign chan_b_out_bus_o = b_bus_q;
   assign chan_a_out_oe_n_o = a_oe_n_q;
   assign chan_b_out_oe_n_o = b_oe_n_q;
   assign out_valid_o = valid_q;
   assign stabiliser_en_o = dcs_q;
   assign twos_complement_o = twos_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_TICK_PACE: assert property (
      (!sleep_w && tick_w) |=> sample_tick_o)
      else $error("sample tick missing at divider wrap");

   AST_OE_A_FOLLOWS: assert property (
      $stable(chan_a_out_enable_n_i) [*2] |->
      chan_a_out_oe_n_o == {SAMPLE_W{chan_a_out_enable_n_i}})
      else $error("channel A enable not reflected on output enables");

   AST_CONVERT_DESPITE_OE: assert property (
      (tick_w && rd_valid_w && !output_hold_i && !sleep_w && chan_a_out_enable_n_i)
      |=> (word_q == $past(rd_pair_w)))
      else $error("conversion stopped while outputs disabled");

   AST_SLEEP_NO_VALID: assert property (
      sleep_w |=> !out_valid_o ##1 !out_valid_o)
      else $error("valid word during sleep");

   AST_SLEEP_FLUSH: assert property (
      sleep_w |=> (!rd_valid_w && !core_ready_o))
      else $error("buffer kept data across sleep");

   AST_WAKE_WAIT: assert property (
      $fell(sleep_w) |-> !out_valid_o [*8])
      else $error("valid word too soon after sleep");

   AST_STAB_SUPPLY: assert property (
      (format_stabiliser_select_i == FSS_SUPPLY) |=> (stabiliser_en_o && !twos_complement_o))
      else $error("supply level decode wrong");

   AST_STAB_MIDREF: assert property (
      (format_stabiliser_select_i == FSS_MIDREF) |=> (!stabiliser_en_o && twos_complement_o))
      else $error("mid reference decode wrong");

   AST_FMT_SETTLE: assert property (
      fmt_chg_w |=> !out_valid_o [*3])
      else $error("valid word during format settle");

   AST_TWOS_CODE: assert property (
      (pop_w && twos_w && !mux_w) |=>
      (chan_a_out_bus_o == {~$past(rd_pair_w.a[SAMPLE_W-1]), $past(rd_pair_w.a[SAMPLE_W-2:0])}))
      else $error("two's complement coding wrong");

   AST_MUX_INDICATOR: assert property (
      (pop_w && mux_w && $stable(mux_w)) |=> chan_b_out_bus_o[0] ##1
      (!chan_b_out_bus_o[0] || !$past(mux_w)))
      else $error("channel indicator sequence wrong");

   AST_MUX_B_WORD: assert property (
      (pop_w && mux_w) |=> ##1 (chan_a_out_bus_o == daoc_code($past(word_q.b), $past(twos_w))))
      else $error("channel B word not shown in period");

   COV_MUX_POP: cover property (pop_w && mux_w ##1 b_phase_q);
   COV_WAKE: cover property ($fell(sleep_w) ##[1:300] out_valid_o);
   COV_FULL: cover property (!wr_ready_w);
   COV_PAR_VALID: cover property (pop_w && !mux_w && ok_w);
endmodule

// >>> tb/daoc_capture_model.sv
// Capture logic model on the far side of the output pins
`timescale 1ns/1ns
module daoc_capture_model import daoc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic mux_i,
   input wire logic [1:0] stall_i,
   input wire logic rnd_i,
   input wire logic [SAMPLE_W-1:0] bus_a_i,
   input wire logic [SAMPLE_W-1:0] oe_a_n_i,
   input wire logic [SAMPLE_W-1:0] bus_b_i,
   input wire logic [SAMPLE_W-1:0] oe_b_n_i,
   input wire logic valid_i,
   output logic hold_o,
   output logic cap_o,
   output daoc_pair_t cap_pair_o
);
   // ----------------------------------------
   // Pin levels, stall and capture
   // ----------------------------------------
   logic [SAMPLE_W-1:0] wa = '0;
   logic [SAMPLE_W-1:0] wb = '0;
   logic [SAMPLE_W-1:0] a_q = '0;
   logic [2*SAMPLE_W-1:0] last_q = '0;
   logic got_q = 1'b0;
   logic hold_q = 1'b0;
   logic cap_q = 1'b0;
   wire logic drv_a = ~|oe_a_n_i;
   wire logic drv_b = mux_i ? ~oe_b_n_i[0] : ~|oe_b_n_i;
   assign hold_o = hold_q;
   assign cap_o = cap_q;
   // Stall: none, always, or random
   always @(posedge sys_clk_i) begin
      hold_q <= #1 (stall_i == 2'h1) || (stall_i == 2'h2 && rnd_i);
   end
   // Released pins float to the inverse of their last level
   always @(posedge sys_clk_i) begin
      wa = (bus_a_i & ~oe_a_n_i) | (~wa & oe_a_n_i);
      wb = (bus_b_i & ~oe_b_n_i) | (~wb & oe_b_n_i);
      cap_q <= 1'b0;
      if (!mux_i) begin
         if (valid_i && drv_a && drv_b && {wa, wb} != last_q) begin
            cap_q <= 1'b1;
            cap_pair_o <= {wa, wb};
            last_q = {wa, wb};
         end
      end else if (valid_i && drv_a && wb[0]) begin
         a_q = wa;
         got_q = 1'b1;
      end else begin
         if (got_q && valid_i && drv_a && drv_b) begin
            cap_q <= 1'b1;
            cap_pair_o <= {a_q, wa};
         end
         got_q = 1'b0;
      end
   end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the dual converter output control
`timescale 1ns/1ns
module tb;
   import daoc_pkg::*;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam int DIV = 2;
   localparam int WAKE = 20;
   localparam int SETTLE = 4;
   localparam int LIMIT = 6000;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic core_valid = 1'b0;
   logic sleep_req = 1'b1;
   logic oe_a_n = 1'b0;
   logic oe_b_n = 1'b0;
   logic mux = 1'b0;
   logic [1:0] sel = FSS_SUPPLY;
   logic [1:0] stall = 2'h0;
   daoc_pair_t core_sample = '0;
   daoc_pair_t cap_pair;
   integer seed = 32'h9A1B23DB;
   logic [31:0] rnd = 32'h0;
   logic core_ready, tick, hold, out_valid, stab, twos, cap;
   logic [SAMPLE_W-1:0] bus_a, chan_a_out_enable_n, bus_b, chan_b_out_enable_n;
   logic [23:0] expq[$];
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   int ncap = 0;
   int seq = 0;

   daoc_top #(.SAMPLE_DIV(DIV), .WAKE_CYCLES(WAKE), .FMT_SETTLE(SETTLE)) DUT (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .core_sample_i(core_sample),
      .core_valid_i(core_valid), .core_ready_o(core_ready), .sample_tick_o(tick),
      .sleep_request_i(sleep_req), .chan_a_out_enable_n_i(oe_a_n),
      .chan_b_out_enable_n_i(oe_b_n), .format_stabiliser_select_i(sel),
      .interleave_select_i(mux), .output_hold_i(hold), .chan_a_out_bus_o(bus_a),
      .chan_a_out_oe_n_o(chan_a_out_enable_n), .chan_b_out_bus_o(bus_b), .chan_b_out_oe_n_o(chan_b_out_enable_n),
      .out_valid_o(out_valid), .stabiliser_en_o(stab), .twos_complement_o(twos));
   daoc_capture_model partner (
      .sys_clk_i(sys_clk), .mux_i(mux), .stall_i(stall), .rnd_i(rnd[31]),
      .bus_a_i(bus_a), .oe_a_n_i(chan_a_out_enable_n), .bus_b_i(bus_b), .oe_b_n_i(chan_b_out_enable_n),
      .valid_i(out_valid), .hold_o(hold), .cap_o(cap), .cap_pair_o(cap_pair));

   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      #1;
      rnd <= $random(seed);
   end

   // ----------------------------------------
   // Model, compare and report
   // ----------------------------------------
   function automatic logic [11:0] cv(input logic [11:0] w);
      return (sel <= FSS_MIDREF) ? {~w[11], w[10:0]} : w;
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         $display("MISMATCH at %0t: run too long", $time);
         conclude();
      end else begin
         if (rst_n && core_valid && core_ready === 1'b1 && !sleep_req) begin
            expq.push_back({cv(core_sample.a), cv(core_sample.b)});
            seq++;
         end
         if (cap === 1'b1) begin
            ncap++;
            if (expq.size() == 0) expq.push_back('x);
            chk(cap_pair, expq.pop_front(), "captured pair");
         end
      end
   end
   task automatic phase(input logic [1:0] s, input logic m, input logic oe,
                        input logic [1:0] st, input int n);
      int t;
      int c0;
      int i;
      logic seen;
      t = 0;
      i = 0;
      seen = 1'b0;
      sleep_req = 1'b1;
      step(2);
      expq.delete();
      sel = s;
      mux = m;
      oe_a_n = oe;
      oe_b_n = oe;
      stall = st;
      repeat (4) begin
         step(1);
         chk(tick, 0, "tick in sleep");
         chk(out_valid, 0, "valid in sleep");
         chk(core_ready, 0, "ready in sleep");
      end
      chk(chan_a_out_enable_n, {12{oe}}, "enable a");
      chk(chan_b_out_enable_n, m ? {11'h7FF, oe} : {12{oe}}, "enable b");
      sleep_req = 1'b0;
      repeat (WAKE) begin
         step(1);
         chk(out_valid, 0, "valid in wake");
      end
      step(8);
      chk({stab, twos}, {s == FSS_GROUND || s == FSS_SUPPLY, s <= FSS_MIDREF}, "decode");
      repeat (10) begin
         step(1);
         t += (tick === 1'b1);
      end
      chk(t, 10 / DIV, "tick rate");
      c0 = ncap;
      repeat (n) begin
         if (oe && i == n / 2) sel = ~s;
         core_valid = (st == 2'h1) || (rnd[1:0] != 2'h0);
         core_sample.a = {rnd[31:24], seq[3:0]};
         core_sample.b = rnd[23:12];
         step(1);
         seen |= (st == 2'h1) ? (core_ready === 1'b0) : (out_valid === 1'b1);
         if (oe && i >= n / 2 && i <= n / 2 + SETTLE) chk(out_valid, 0, "select settle");
         i++;
      end
      core_valid = 1'b0;
      stall = 2'h0;
      t = 0;
      while (!oe && expq.size() != 0 && t < 400) begin
         step(1);
         t++;
      end
      step(oe ? 60 : 6);
      if (st == 2'h1) chk(seen, 1, "buffer refused");
      if (m) chk(bus_b & 12'hFFE, 0, "indicator lane");
      if (oe) begin
         chk(seen, 1, "conversion while released");
         chk(ncap - c0, 0, "capture while released");
         chk(core_ready, 1, "buffer drained");
      end else chk(expq.size(), 0, "pairs left");
      $display("Test sel %0d mux %0d off %0d stall %0d done", s, m, oe, st);
   endtask

   initial begin
      step(3);
      rst_n = 1'b1;
      phase(FSS_SUPPLY, 1'b0, 1'b0, 2'h0, 40);
      phase(FSS_GROUND, 1'b1, 1'b0, 2'h0, 40);
      phase(FSS_MIDREF, 1'b0, 1'b0, 2'h2, 40);
      phase(FSS_FLOAT, 1'b1, 1'b0, 2'h1, 30);
      phase(FSS_SUPPLY, 1'b0, 1'b1, 2'h0, 30);
      phase(FSS_GROUND, 1'b0, 1'b0, 2'h1, 30);
      conclude();
   end
endmodule
